// ### src/hs_counter_map.vh
// register offsets, field positions, reset values and counts of the counter bank
`ifndef HS_COUNTER_MAP_VH
`define HS_COUNTER_MAP_VH
`define NUM_CTR        20
`define CTR_BASE_INDEX 236
`define NUM_SLOT       6
`define NUM_POS        6
`define CI_BASE        20
`define PI_BASE        53
`define SLOT_OFF       3'd0
`define SLOT_SET       3'd1
`define SLOT_RESET     3'd2
`define SLOT_CINT      3'd3
`define SLOT_PINT      3'd4
// word addresses (byte address = offset)
`define A_ARM          8'h00
`define A_DIR          8'h04
`define A_CLR          8'h08
`define A_CONTACT      8'h0C
`define A_IRQ_STAT     8'h10
`define A_IRQ_MASK     8'h14
`define A_TARGET       8'h18
`define A_CTR_SEL      8'h1C
`define A_CTR_VAL      8'h20
`define A_CTR_PRE      8'h24
`define A_SLOT_SEL     8'h28
`define A_SLOT_CFG     8'h2C
`define A_SLOT_CMP     8'h30
`define A_POS_SEL      8'h34
`define A_POS_VAL      8'h38
// slot config field positions
`define CFG_TYPE_LSB   0
`define CFG_CTR_LSB    4
`define CFG_TGT_LSB    12
`define CFG_INT_LSB    20
`define CFG_RESET      32'h0000_0000
`endif

// ### src/hs_counter_unit.v
// one pulse counter with contact bit
`timescale 1ns/1ps
module hs_counter_unit (
	input  wire        ref_clk,    // clock
	input  wire        srst,       // sync reset
	input  wire        armed,      // counter driven
	input  wire        pulseIn,    // count input
	input  wire        countDown,  // direction
	input  wire        clear,      // clear count
	input  wire        load,       // program load
	input  wire [31:0] loadVal,    // load value
	input  wire [31:0] preset,     // contact preset
	output reg  [31:0] count_q,    // counter value
	output reg         contact_q,  // contact bit
	output wire        step,       // count edge this cycle
	output wire [31:0] nextCount   // value after this edge
);
	reg pulsePrev_q;
	wire rise = pulseIn & ~pulsePrev_q;
	assign step = armed & rise & ~clear & ~load;
	assign nextCount = countDown ? count_q - 32'h0000_0001 : count_q + 32'h0000_0001;
	always @(posedge ref_clk) begin
		if (srst) begin
			pulsePrev_q <= 1'b0;
			count_q     <= 32'h0000_0000;
			contact_q   <= 1'b0;
		end else begin
			pulsePrev_q <= pulseIn;
			if (clear) begin
				count_q   <= 32'h0000_0000;
				contact_q <= 1'b0;
			end else if (load) begin
				count_q <= loadVal;
			end else if (step) begin
				count_q <= nextCount;
				if (!countDown && nextCount == preset)
					contact_q <= 1'b1;
				else if (countDown && count_q == preset)
					contact_q <= 1'b0;
			end
		end
	end
endmodule // hs_counter_unit

// ### src/hs_counter_compare.v
// high-speed counter bank with match compare slots and wishbone registers
// Behaviour
// - count only when armed, on rising input
// - twenty counters selected by index
// - signed 32-bit preset per counter
// - contact sets at preset, clears counting down from it
// - reset command clears count and contact
// - unarmed counter ignores input pulses
// - direction bit on counts down
// - set slot sets target immediately on match
// - program loads never trigger compares
// - only first six slots may be active
// - interrupt slot raises numbered interrupt
// - position slot interrupts on position equality
// - position writes never raise interrupt
// - reset slot clears target immediately on match
`timescale 1ns/1ps
`include "hs_counter_map.vh"
module hs_counter_compare (
	input  wire        ref_clk,                    // 100 MHz clock
	input  wire        srst,                       // sync reset, high
	input  wire [19:0] pulseIn,                    // counter pulse pins
	input  wire [19:0] counterArmCommand,          // drive level per counter
	input  wire [19:0] countDirectionBit,          // 1 = count down
	input  wire [5:0]  posUpdate,                  // motion moved position
	input  wire [191:0] posMotionVal,              // new position per source
	input  wire        wb_cyc_i,                   // wishbone cycle
	input  wire        wb_stb_i,                   // wishbone strobe
	input  wire        wb_we_i,                    // write enable
	input  wire [7:0]  wb_adr_i,                   // byte address
	input  wire [3:0]  wb_sel_i,                   // byte lanes
	input  wire [31:0] wb_dat_i,                   // write data
	output reg  [31:0] wb_dat_o,                   // read data
	output reg         wb_ack_o,                   // ack
	output reg  [31:0] targetOut,                  // target bits / output pins
	output wire [19:0] contactOut,                 // contact bits
	output wire        irq                         // level interrupt
);
	localparam ST_IDLE = 2'b01;
	localparam ST_ACK  = 2'b10;
	reg  [1:0]   state_q;
	reg  [19:0]  armReg_q, dirReg_q;
	reg  [4:0]   ctrSel_q;
	reg  [2:0]   slotSel_q, posSel_q;
	reg  [31:0]  preset_q [0:19];
	reg  [31:0]  slotCfg_q [0:5];
	reg  [31:0]  slotCmp_q [0:5];
	reg  [31:0]  pos_q [0:5];
	reg  [11:0]  irqStat_q, irqMask_q;
	wire [31:0]  count [0:19];
	wire [31:0]  nxt [0:19];
	wire [19:0]  step;
	wire [19:0]  armed = armReg_q | counterArmCommand;
	wire [19:0]  dirDown = dirReg_q | countDirectionBit;
	wire         acc = wb_cyc_i & wb_stb_i & state_q[0];
	wire         wr = acc & wb_we_i & (wb_sel_i == 4'hF);
	wire [31:0]  wsel = (wb_dat_i & {{8{wb_sel_i[3]}},{8{wb_sel_i[2]}},{8{wb_sel_i[1]}},{8{wb_sel_i[0]}}});
	wire [19:0]  clrCmd = (acc && wb_we_i && wb_adr_i == `A_CLR) ? wb_dat_i[19:0] : 20'h0_0000;
	wire         valid = ctrSel_q < `NUM_CTR;

	genvar g;
	generate
		for (g = 0; g < `NUM_CTR; g = g + 1) begin : ctr
			hs_counter_unit u (
				.ref_clk   (ref_clk),
				.srst      (srst),
				.armed     (armed[g]),
				.pulseIn   (pulseIn[g]),
				.countDown (dirDown[g]),
				.clear     (clrCmd[g]),
				.load      (wr && wb_adr_i == `A_CTR_VAL && valid && ctrSel_q == g),
				.loadVal   (wb_dat_i),
				.preset    (preset_q[g]),
				.count_q   (count[g]),
				.contact_q (contactOut[g]),
				.step      (step[g]),
				.nextCount (nxt[g])
			);
		end
	endgenerate

	// slot evaluation: combinational so the match takes effect on the counting edge itself
	reg [31:0] tgtSet, tgtClr;
	reg [11:0] evt;
	reg [2:0]  typ;
	reg [4:0]  ci;
	reg [4:0]  tb;
	reg [2:0]  ii;
	integer s;
	always @* begin
		tgtSet = 32'h0000_0000;
		tgtClr = 32'h0000_0000;
		evt    = 12'h000;
		typ    = 3'd0;
		ci     = 5'd0;
		tb     = 5'd0;
		ii     = 3'd0;
		for (s = 0; s < `NUM_SLOT; s = s + 1) begin
			typ = slotCfg_q[s][`CFG_TYPE_LSB +: 3];
			ci  = slotCfg_q[s][`CFG_CTR_LSB +: 5];
			tb  = slotCfg_q[s][`CFG_TGT_LSB +: 5];
			ii  = slotCfg_q[s][`CFG_INT_LSB +: 3];
			if (ci < `NUM_CTR && step[ci] && nxt[ci] == slotCmp_q[s]) begin
				if (typ == `SLOT_SET)
					tgtSet[tb] = 1'b1;
				else if (typ == `SLOT_RESET)
					tgtClr[tb] = 1'b1;
				else if (typ == `SLOT_CINT && ii < 3'd6)
					evt[ii] = 1'b1;
			end
			if (typ == `SLOT_PINT && ii < 3'd6 && posUpdate[ii] &&
				posMotionVal[ii*32 +: 32] == slotCmp_q[s])
				evt[6 + ii] = 1'b1;
		end
	end

	wire [31:0] preRd = valid ? preset_q[ctrSel_q] : 32'h0000_0000;
	wire [31:0] cntRd = valid ? count[ctrSel_q] : 32'h0000_0000;
	always @* begin
		case (wb_adr_i)
		`A_ARM:      wb_dat_o = {12'h000, armReg_q};
		`A_DIR:      wb_dat_o = {12'h000, dirReg_q};
		`A_CONTACT:  wb_dat_o = {12'h000, contactOut};
		`A_IRQ_STAT: wb_dat_o = {20'h0_0000, irqStat_q};
		`A_IRQ_MASK: wb_dat_o = {20'h0_0000, irqMask_q};
		`A_TARGET:   wb_dat_o = targetOut;
		`A_CTR_SEL:  wb_dat_o = {27'h000_0000, ctrSel_q};
		`A_CTR_VAL:  wb_dat_o = cntRd;
		`A_CTR_PRE:  wb_dat_o = preRd;
		`A_SLOT_SEL: wb_dat_o = {29'h000_0000, slotSel_q};
		`A_SLOT_CFG: wb_dat_o = slotSel_q < 3'd6 ? slotCfg_q[slotSel_q] : 32'h0000_0000;
		`A_SLOT_CMP: wb_dat_o = slotSel_q < 3'd6 ? slotCmp_q[slotSel_q] : 32'h0000_0000;
		`A_POS_SEL:  wb_dat_o = {29'h000_0000, posSel_q};
		`A_POS_VAL:  wb_dat_o = posSel_q < 3'd6 ? pos_q[posSel_q] : 32'h0000_0000;
		default:     wb_dat_o = 32'h0000_0000;
		endcase
	end

	assign irq = |(irqStat_q & irqMask_q);

	integer k;
	always @(posedge ref_clk) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			wb_ack_o  <= 1'b0;
			armReg_q  <= 20'h0_0000;
			dirReg_q  <= 20'h0_0000;
			ctrSel_q  <= 5'd0;
			slotSel_q <= 3'd0;
			posSel_q  <= 3'd0;
			irqStat_q <= 12'h000;
			irqMask_q <= 12'h000;
			targetOut <= 32'h0000_0000;
			for (k = 0; k < 20; k = k + 1)
				preset_q[k] <= 32'h0000_0000;
			for (k = 0; k < 6; k = k + 1) begin
				slotCfg_q[k] <= `CFG_RESET;
				slotCmp_q[k] <= 32'h0000_0000;
				pos_q[k]     <= 32'h0000_0000;
			end
		end else begin
			case (state_q)
			ST_IDLE: begin
				wb_ack_o <= acc;
				if (acc)
					state_q <= ST_ACK;
			end
			ST_ACK: begin
				wb_ack_o <= 1'b0;
				state_q  <= ST_IDLE;
			end
			default: begin
				wb_ack_o <= 1'b0;
				state_q  <= ST_IDLE;
			end
			endcase
			// set wins over clear: hardware match beats software write in the same cycle
			targetOut <= (targetOut & ~tgtClr) | tgtSet;
			irqStat_q <= (irqStat_q & ~((wr && wb_adr_i == `A_IRQ_STAT) ?
				wb_dat_i[11:0] : 12'h000)) | evt;
			for (k = 0; k < 6; k = k + 1)
				if (posUpdate[k])
					pos_q[k] <= posMotionVal[k*32 +: 32];
			if (wr) begin
				case (wb_adr_i)
				`A_ARM:      armReg_q  <= wsel[19:0];
				`A_DIR:      dirReg_q  <= wsel[19:0];
				`A_IRQ_MASK: irqMask_q <= wsel[11:0];
				`A_TARGET:   targetOut <= (wsel & ~tgtClr) | tgtSet;
				`A_CTR_SEL:  ctrSel_q  <= wsel[4:0];
				`A_CTR_PRE:  if (valid) preset_q[ctrSel_q] <= wsel;
				`A_SLOT_SEL: slotSel_q <= wsel[2:0];
				`A_SLOT_CFG: if (slotSel_q < 3'd6) slotCfg_q[slotSel_q] <= wsel;
				`A_SLOT_CMP: if (slotSel_q < 3'd6) slotCmp_q[slotSel_q] <= wsel;
				`A_POS_SEL:  posSel_q  <= wsel[2:0];
				`A_POS_VAL:  if (posSel_q < 3'd6) pos_q[posSel_q] <= wsel;
				default:     armReg_q  <= armReg_q;
				endcase
			end
		end
	end
endmodule // hs_counter_compare

// ### tb/hs_counter_checker.sv
// port assertions for the counter bank
`timescale 1ns/1ps
`include "hs_counter_map.vh"
module hs_counter_checker (
	input wire        ref_clk,    // clock
	input wire        srst,       // reset
	input wire [19:0] pulseIn,    // pins
	input wire [5:0]  posUpdate,  // motion
	input wire        wb_cyc_i,   // cycle
	input wire        wb_stb_i,   // strobe
	input wire        wb_we_i,    // write
	input wire [7:0]  wb_adr_i,   // address
	input wire        wb_ack_o,   // ack
	input wire [31:0] targetOut,  // targets
	input wire [19:0] contactOut, // contacts
	input wire        irq         // interrupt
);
	reg  [19:0] pinPrev_q;
	reg  [19:0] pinEdge_q;
	wire        wrAck = wb_ack_o & wb_we_i;
	// an edge seen at one clock may only move results visible at the next
	always @(posedge ref_clk) begin
		pinPrev_q <= pulseIn;
		pinEdge_q <= pulseIn & ~pinPrev_q;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_ack_next: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
		else $error("ack not in next cycle");
	chk_contact_set: assert property (~|(contactOut & ~$past(contactOut) & ~pinEdge_q))
		else $error("contact set without edge");
	chk_contact_clr: assert property ((|(~contactOut & $past(contactOut) & ~pinEdge_q))
		|-> wrAck && wb_adr_i == `A_CLR) else $error("contact cleared without cause");
	chk_irq_rise: assert property ($rose(irq) |-> (|pinEdge_q) || (|$past(posUpdate))
		|| (wrAck && wb_adr_i == `A_IRQ_MASK)) else $error("irq raised without cause");
	chk_irq_fall: assert property ($fell(irq) |-> wrAck)
		else $error("irq dropped without write");
	chk_target_set: assert property ((|(targetOut & ~$past(targetOut)))
		|-> (|pinEdge_q) || (wrAck && wb_adr_i == `A_TARGET)) else $error("target set late");
	chk_target_clr: assert property ((|(~targetOut & $past(targetOut)))
		|-> (|pinEdge_q) || (wrAck && wb_adr_i == `A_TARGET)) else $error("target clr late");
endmodule // hs_counter_checker

// ### tb/pulse_source.sv
// external pulse source feeding one counter pin
`timescale 1ns/1ps
module pulse_source (
	input  wire       ref_clk,      // clock
	input  wire       go,           // start burst
	input  wire [7:0] num,          // pulses
	input  wire [3:0] gap,          // extra low cycles
	output reg        pulse = 1'h0, // pin
	output reg        busy = 1'h0   // burst running
);
	reg [7:0] left = 8'h00;
	reg [3:0] waitC = 4'h0;
	// every pulse is followed by at least one low sample so each edge is seen
	always @(posedge ref_clk) begin
		if (go && !busy) begin
			left <= num;
			busy <= 1'h1;
		end else if (busy && pulse) begin
			pulse <= 1'h0;
			waitC <= gap;
		end else if (busy && waitC != 4'h0) begin
			waitC <= waitC - 4'h1;
		end else if (busy && left != 8'h00) begin
			pulse <= 1'h1;
			left <= left - 8'h01;
		end else begin
			busy <= 1'h0;
		end
	end
endmodule // pulse_source

// ### tb/test_high_speed_counter_compare.sv
// self-checking bench for the counter bank
`timescale 1ns/1ps
`include "hs_counter_map.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module test_high_speed_counter_compare;
	reg        ref_clk = 0, srst = 1, cyc = 0, we = 0, go = 0, pUp = 0, armC = 0, dirC = 0;
	reg [7:0]  adr = 0, num = 0;
	reg [3:0]  gap = 0;
	reg [31:0] dat = 0, rd, pos = 0, seed = 32'h0000_01c3;
	wire [31:0] dO, tgtOut;
	wire [19:0] con;
	wire        ack, irq, srcPin, srcBusy;
	int errors = 0, n_checks = 0, cnt = 0, con0 = 0, tgt = 0, st = 0, cycN = 0;
	hs_counter_compare dut_u (.ref_clk(ref_clk), .srst(srst), .pulseIn({seed[31:13], srcPin}),
		.counterArmCommand({19'h0_0000, armC}), .countDirectionBit({seed[19:1], dirC}),
		.posUpdate({5'h00, pUp}), .posMotionVal({{5{seed}}, pos}), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dO), .wb_ack_o(ack), .targetOut(tgtOut), .contactOut(con), .irq(irq));
	pulse_source src_u (.ref_clk(ref_clk), .go(go), .num(num), .gap(gap), .pulse(srcPin),
		.busy(srcBusy));
	always #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// unarmed pins get random pulses and directions all run long
	always @(posedge ref_clk) begin
		seed <= xs(seed);
		cycN <= cycN + 1;
		if (cycN == 5000) begin
			errors++;
			close_out;
		end
	end
	// no local limit: a missing ack is caught by the cycle ceiling
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'h1);
		rd = dO;
		cyc <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic step(input int d);
		int o;
		o = cnt;
		cnt += d;
		if (o == 2 && cnt == 3) con0 = 1;
		if (o == 3 && cnt == 2) con0 = 0;
		if (cnt == 2) tgt = 32'h0000_0020;
		if (cnt == 5) tgt = 0;
		if (cnt == 4) st |= 4;
	endtask
	task automatic burst(input int n);
		int k;
		for (k = 0; k < n; k++)
			if (armC) step(dirC ? -1 : 1);
		num <= n[7:0];
		gap <= {1'h0, seed[2:0]};
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
		do begin
			@(posedge ref_clk);
		end while (srcBusy !== 1'h0);
	endtask
	task automatic look;
		bus(0, `A_CTR_VAL, 0);
		`CHK(rd, cnt[31:0])
		`CHK(con, {19'h0_0000, con0[0]})
		`CHK(tgtOut, tgt[31:0])
		bus(0, `A_IRQ_STAT, 0);
		`CHK(rd, st[31:0])
	endtask
	task automatic cfg(input logic [7:0] s, input logic [31:0] c, input logic [31:0] v);
		bus(1, `A_SLOT_SEL, {24'h00_0000, s});
		bus(1, `A_SLOT_CMP, v);
		bus(1, `A_SLOT_CFG, c);
	endtask
	task close_out;
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'h0;
		@(posedge ref_clk);
		burst(3);
		look;
		bus(1, `A_CTR_PRE, 32'h0000_0003);
		cfg(0, 32'h0000_5001, 32'h0000_0002);
		cfg(1, 32'h0020_0003, 32'h0000_0004);
		cfg(2, 32'h0000_5002, 32'h0000_0005);
		cfg(3, 32'h0000_0004, 32'h0000_0007);
		bus(1, `A_IRQ_MASK, 32'h0000_0FFF);
		armC <= 1'h1;
		@(posedge ref_clk);
		burst(3);
		look;
		burst(2);
		look;
		`CHK(irq, 1'h1)
		bus(1, `A_IRQ_MASK, 0);
		`CHK(irq, 1'h0)
		bus(1, `A_IRQ_MASK, 32'h0000_0FFF);
		bus(1, `A_IRQ_STAT, 32'h0000_0FFF);
		st = 0;
		`CHK(irq, 1'h0)
		dirC <= 1'h1;
		@(posedge ref_clk);
		burst(3);
		look;
		dirC <= 1'h0;
		@(posedge ref_clk);
		burst(1);
		bus(1, `A_CLR, 32'h0000_0001);
		cnt = 0;
		con0 = 0;
		look;
		bus(1, `A_IRQ_STAT, 32'h0000_0FFF);
		st = 0;
		bus(1, `A_CTR_VAL, 32'h0000_0004);
		cnt = 4;
		bus(1, `A_POS_VAL, 32'h0000_0007);
		look;
		pos <= 32'h0000_0007;
		pUp <= 1'h1;
		@(posedge ref_clk);
		pUp <= 1'h0;
		st = 32'h0000_0040;
		look;
		bus(0, 8'h3C, 0);
		`CHK(rd, 32'h0000_0000)
		close_out;
	end
endmodule // test_high_speed_counter_compare
bind hs_counter_compare hs_counter_checker chk_u (.*);
